// *** src/adc_capture_pkg.sv ***
// Shared constants and types for the converter output capture block
package adc_capture_pkg;

	// ------------------------------------------------------------
	// Widths and depths
	// ------------------------------------------------------------
	localparam int WORD_WIDTH   = 10;
	localparam int ANALOG_WIDTH = 12;
	localparam int PIPE_DEPTH   = 6;
	localparam int FIFO_DEPTH   = 4;
	localparam int STAGE_COUNT  = PIPE_DEPTH - 1;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS   = 8;
	localparam int APERTURE_DELAY_NS = 2;
	localparam int APERTURE_RAW      =
		(APERTURE_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int APERTURE_CYCLES   = (APERTURE_RAW < 1) ? 1 : APERTURE_RAW;
	localparam int APERTURE_WIDTH    = 4;
	localparam logic [APERTURE_WIDTH-1:0] APERTURE_LOAD =
		APERTURE_WIDTH'(APERTURE_CYCLES);
	localparam logic [APERTURE_WIDTH-1:0] APERTURE_LAST = 4'h1;
	localparam logic [APERTURE_WIDTH-1:0] APERTURE_IDLE = 4'h0;

	// ------------------------------------------------------------
	// Analog full scale and output codes
	// ------------------------------------------------------------
	localparam logic signed [ANALOG_WIDTH-1:0] FULL_SCALE_POS = 12'sh1ff;
	localparam logic signed [ANALOG_WIDTH-1:0] FULL_SCALE_NEG = 12'she00;
	localparam logic [WORD_WIDTH-1:0] CODE_ALL_ZEROS = 10'h000;
	localparam logic [WORD_WIDTH-1:0] CODE_ALL_ONES  = 10'h3ff;
	localparam int SIGN_BIT = WORD_WIDTH - 1;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic                  out_of_range;
		logic [WORD_WIDTH-1:0] word;
	} sample_type;

	localparam int SAMPLE_WIDTH = $bits(sample_type);
	localparam sample_type SAMPLE_RESET = '{1'b0, CODE_ALL_ZEROS};

	typedef struct packed {
		logic                            sclk_prev;
		logic [APERTURE_WIDTH-1:0]       aperture_cnt;
		sample_type                      held;
		logic                            held_valid;
		sample_type [STAGE_COUNT-1:0]    pipe;
		logic [STAGE_COUNT-1:0]          pipe_valid;
		sample_type                      out;
		logic                            out_valid;
		logic                            push;
	} capture_state_type;

	localparam capture_state_type STATE_RESET = '{
		sclk_prev:    1'b0,
		aperture_cnt: APERTURE_IDLE,
		held:         SAMPLE_RESET,
		held_valid:   1'b0,
		pipe:         '{default: SAMPLE_RESET},
		pipe_valid:   '0,
		out:          SAMPLE_RESET,
		out_valid:    1'b0,
		push:         1'b0
	};

endpackage : adc_capture_pkg

// *** src/adc_output_capture_ctrl.sv ***
// Digital output side of a pipelined converter: sampling, latency, coding
`timescale 1ns/1ns
// Summary of operation
// - Code is offset binary: negative full scale zeros, positive ones
// - Word appears exactly six sample clock cycles after its sample
// - Sample taken one aperture delay after sample clock falling edge
// - Range flag high when input above or below full scale
// - Ten-bit parallel word, bit zero is least significant
// - Select high uses external reference, internal one powered down
// - Power-down input low powers down, high runs normally
module adc_output_capture_ctrl
	import adc_capture_pkg::*;
(
	input  wire logic                           clock_in,
	input  wire logic                           reset_n_in,
	input  wire logic                           sample_clock_in,
	input  wire logic signed [ANALOG_WIDTH-1:0] analog_level_in,
	input  wire logic                           reference_source_select_in,
	input  wire logic                           power_down_n_in,
	output logic             [WORD_WIDTH-1:0]   sample_word_bits_out,
	output logic                                range_exceeded_out,
	output logic                                word_valid_out,
	output logic                                internal_ref_enable_out,
	output logic                                external_ref_active_out,
	output logic             [SAMPLE_WIDTH-1:0] stream_data_out,
	output logic                                stream_valid_out,
	input  wire logic                           stream_ready_in,
	output logic                                buffer_ready_out
);

	localparam int AP_WAIT = APERTURE_CYCLES - 1;

	capture_state_type state_r;
	capture_state_type state_nxt;
	logic              fall_edge;
	logic              take;
	logic              fifo_in_ready;

	// ------------------------------------------------------------
	// Quantiser
	// ------------------------------------------------------------
	function automatic sample_type quantise(
		input logic signed [ANALOG_WIDTH-1:0] level);
		sample_type s;
		s.out_of_range = 1'b0;
		s.word         = CODE_ALL_ZEROS;
		if (level > FULL_SCALE_POS)
		begin
			s.out_of_range = 1'b1;
			s.word         = CODE_ALL_ONES;
		end
		else if (level < FULL_SCALE_NEG)
		begin
			s.out_of_range = 1'b1;
			s.word         = CODE_ALL_ZEROS;
		end
		else
		begin
			s.word = level[WORD_WIDTH-1:0];
			s.word[SIGN_BIT] = ~level[SIGN_BIT];
		end
		return s;
	endfunction : quantise

	// ------------------------------------------------------------
	// Sampling and pipeline
	// ------------------------------------------------------------
	assign fall_edge = state_r.sclk_prev && !sample_clock_in;
	assign take      = (state_r.aperture_cnt == APERTURE_LAST);

	always_comb
	begin
		state_nxt           = state_r;
		state_nxt.sclk_prev = sample_clock_in;
		state_nxt.push      = 1'b0;
		if (!power_down_n_in)
		begin
			state_nxt           = STATE_RESET;
			state_nxt.sclk_prev = sample_clock_in;
		end
		else
		begin
			if (state_r.aperture_cnt != APERTURE_IDLE)
				state_nxt.aperture_cnt = state_r.aperture_cnt - 1'b1;
			if (take)
			begin
				state_nxt.held       = quantise(analog_level_in);
				state_nxt.held_valid = 1'b1;
			end
			if (fall_edge)
			begin
				state_nxt.aperture_cnt = APERTURE_LOAD;
				state_nxt.pipe = {state_r.pipe[STAGE_COUNT-2:0],
					state_r.held};
				state_nxt.pipe_valid = {state_r.pipe_valid[STAGE_COUNT-2:0],
					state_r.held_valid};
				state_nxt.out       = state_r.pipe[STAGE_COUNT-1];
				state_nxt.out_valid = state_r.pipe_valid[STAGE_COUNT-1];
				state_nxt.push      = state_r.pipe_valid[STAGE_COUNT-1];
			end
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (!reset_n_in)
			state_r <= STATE_RESET;
		else
			state_r <= state_nxt;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign sample_word_bits_out    = state_r.out.word;
	assign range_exceeded_out      = state_r.out.out_of_range;
	assign word_valid_out          = state_r.out_valid;
	assign internal_ref_enable_out =
		!reference_source_select_in && power_down_n_in;
	assign external_ref_active_out = reference_source_select_in;
	assign buffer_ready_out        = fifo_in_ready;

	// ------------------------------------------------------------
	// Output word buffer
	// ------------------------------------------------------------
	sample_fifo #(
		.WIDTH (SAMPLE_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) sample_fifo_i (
		.clock_in      (clock_in),
		.reset_n_in    (reset_n_in),
		.in_data_in    (state_r.out),
		.in_valid_in   (state_r.push),
		.in_ready_out  (fifo_in_ready),
		.out_data_out  (stream_data_out),
		.out_valid_out (stream_valid_out),
		.out_ready_in  (stream_ready_in)
	);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_code_min;
		@(posedge clock_in) disable iff (!reset_n_in)
		take && power_down_n_in && analog_level_in < FULL_SCALE_NEG
		|=> state_r.held.word == CODE_ALL_ZEROS;
	endproperty
	a_code_min: assert property (p_code_min)
		else $error("Below scale input did not give all zeros");

	property p_code_max;
		@(posedge clock_in) disable iff (!reset_n_in)
		take && power_down_n_in && analog_level_in > FULL_SCALE_POS
		|=> state_r.held.word == CODE_ALL_ONES;
	endproperty
	a_code_max: assert property (p_code_max)
		else $error("Above scale input did not give all ones");

	property p_latency;
		@(posedge clock_in) disable iff (!reset_n_in)
		fall_edge && power_down_n_in
		|=> sample_word_bits_out == $past(state_r.pipe[STAGE_COUNT-1].word)
			&& word_valid_out == $past(state_r.pipe_valid[STAGE_COUNT-1]);
	endproperty
	a_latency: assert property (p_latency)
		else $error("Output word not from last pipeline stage");

	property p_aperture;
		@(posedge clock_in) disable iff (!reset_n_in)
		fall_edge && power_down_n_in
		##1 (power_down_n_in && !fall_edge) [*1]
		|-> ##AP_WAIT take;
	endproperty
	a_aperture: assert property (p_aperture)
		else $error("Sample not taken one aperture delay after edge");

	property p_range_flag;
		@(posedge clock_in) disable iff (!reset_n_in)
		take && power_down_n_in
		|=> state_r.held.out_of_range ==
			($past(analog_level_in) > FULL_SCALE_POS ||
			 $past(analog_level_in) < FULL_SCALE_NEG);
	endproperty
	a_range_flag: assert property (p_range_flag)
		else $error("Range flag disagrees with input level");

	property p_lsb;
		@(posedge clock_in) disable iff (!reset_n_in)
		take && power_down_n_in && !state_nxt.held.out_of_range
		|=> state_r.held.word[0] == $past(analog_level_in[0]);
	endproperty
	a_lsb: assert property (p_lsb)
		else $error("Least significant bit misplaced");

	property p_reference;
		@(posedge clock_in) disable iff (!reset_n_in)
		reference_source_select_in |-> !internal_ref_enable_out
			&& external_ref_active_out;
	endproperty
	a_reference: assert property (p_reference)
		else $error("Internal reference on while external selected");

	property p_power_down;
		@(posedge clock_in) disable iff (!reset_n_in)
		!power_down_n_in |=> !word_valid_out
			&& sample_word_bits_out == CODE_ALL_ZEROS && !state_r.push;
	endproperty
	a_power_down: assert property (p_power_down)
		else $error("Output active while powered down");

	property p_word_hold;
		@(posedge clock_in) disable iff (!reset_n_in)
		!fall_edge && power_down_n_in
		|=> $stable(sample_word_bits_out) && $stable(range_exceeded_out)
			&& $stable(word_valid_out);
	endproperty
	a_word_hold: assert property (p_word_hold)
		else $error("Output word changed between sample clock edges");

	property p_flag_latency;
		@(posedge clock_in) disable iff (!reset_n_in)
		fall_edge && power_down_n_in
		|=> range_exceeded_out
			== $past(state_r.pipe[STAGE_COUNT-1].out_of_range);
	endproperty
	a_flag_latency: assert property (p_flag_latency)
		else $error("Range flag not aligned with its output word");

endmodule : adc_output_capture_ctrl

// *** src/sample_fifo.sv ***
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
module sample_fifo
	import adc_capture_pkg::*;
#(
	parameter int WIDTH = SAMPLE_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
)(
	input  wire logic             clock_in,
	input  wire logic             reset_n_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	output logic      [WIDTH-1:0] out_data_out,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_PTR   = PTR_W'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0]            wr_ptr;
		logic [PTR_W-1:0]            rd_ptr;
		logic [CNT_W-1:0]            count;
	} fifo_state_type;

	fifo_state_type state_r;
	fifo_state_type state_nxt;
	logic           do_push;
	logic           do_pop;

	assign in_ready_out  = (state_r.count != FULL_COUNT);
	assign out_valid_out = (state_r.count != '0);
	assign out_data_out  = state_r.mem[state_r.rd_ptr];
	assign do_push       = in_valid_in && in_ready_out;
	assign do_pop        = out_valid_out && out_ready_in;

	always_comb
	begin
		state_nxt = state_r;
		if (do_push)
		begin
			state_nxt.mem[state_r.wr_ptr] = in_data_in;
			state_nxt.wr_ptr = (state_r.wr_ptr == LAST_PTR) ? '0
				: state_r.wr_ptr + 1'b1;
		end
		if (do_pop)
			state_nxt.rd_ptr = (state_r.rd_ptr == LAST_PTR) ? '0
				: state_r.rd_ptr + 1'b1;
		if (do_push && !do_pop)
			state_nxt.count = state_r.count + 1'b1;
		else if (do_pop && !do_push)
			state_nxt.count = state_r.count - 1'b1;
	end

	always_ff @(posedge clock_in)
	begin
		if (!reset_n_in)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end

endmodule : sample_fifo

// *** tb/adc_output_capture_ctrl_tb.sv ***
// Self-checking bench for the converter output capture block
`timescale 1ns/1ns
module adc_output_capture_ctrl_tb
	import adc_capture_pkg::*;
;
	logic                           clock = 1'b0;
	logic                           reset_n = 1'b0;
	logic                           run = 1'b0;
	logic                           sclk;
	logic signed [ANALOG_WIDTH-1:0] level = '0;
	logic                           sel = 1'b0;
	logic                           pd_n = 1'b1;
	logic                           ready = 1'b0;
	logic        [WORD_WIDTH-1:0]   word;
	logic                           flag;
	logic                           valid;
	logic                           int_ref;
	logic                           ext_ref;
	logic        [SAMPLE_WIDTH-1:0] s_data;
	logic                           s_valid;
	logic                           b_ready;
	sample_type                     cap;
	sample_type                     q[$];
	sample_type                     sq[$];
	int                             fcnt = 0;
	int                             err_total = 0;
	int                             n_checks = 0;
	logic signed [ANALOG_WIDTH-1:0] levels[10] = '{12'she00, 12'sh1ff,
		12'sh000, 12'shfff, 12'sh200, 12'shdff, 12'sh7ff, 12'sh800,
		12'sh001, 12'sh155};

	always #4 clock = ~clock;

	adc_output_capture_ctrl adc_output_capture_ctrl_i (
		.clock_in(clock), .reset_n_in(reset_n), .sample_clock_in(sclk),
		.analog_level_in(level), .reference_source_select_in(sel),
		.power_down_n_in(pd_n), .sample_word_bits_out(word),
		.range_exceeded_out(flag), .word_valid_out(valid),
		.internal_ref_enable_out(int_ref), .external_ref_active_out(ext_ref),
		.stream_data_out(s_data), .stream_valid_out(s_valid),
		.stream_ready_in(ready), .buffer_ready_out(b_ready));

	capture_partner capture_partner_i (
		.clock_in(clock), .run_in(run), .word_in(word), .flag_in(flag),
		.sample_clock_out(sclk), .captured_out(cap));

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	function automatic sample_type exp_of(input logic signed [11:0] l);
		if (l > FULL_SCALE_POS)
			return '{1'b1, CODE_ALL_ONES};
		if (l < FULL_SCALE_NEG)
			return '{1'b1, CODE_ALL_ZEROS};
		return '{1'b0, WORD_WIDTH'(l - FULL_SCALE_NEG)};
	endfunction : exp_of

	task automatic test_done();
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic step(input logic signed [ANALOG_WIDTH-1:0] l);
		sample_type e;
		@(posedge sclk);
		@(negedge clock);
		level = l;
		q.push_back(exp_of(l));
		@(negedge sclk);
		repeat (3) @(negedge clock);
		level = ~l;
		@(negedge clock);
		check(valid, q.size() > PIPE_DEPTH);
		if (q.size() > PIPE_DEPTH)
		begin
			e = q.pop_front();
			check({flag, word}, e);
			check(cap, e);
			if (fcnt < FIFO_DEPTH)
			begin
				sq.push_back(e);
				fcnt++;
			end
		end
		check(b_ready, fcnt < FIFO_DEPTH);
	endtask : step

	task automatic drain();
		int n;
		@(negedge clock);
		ready = 1'b1;
		while (sq.size() > 0)
		begin
			n = 0;
			while (s_valid !== 1'b1 && n < 20)
			begin
				@(negedge clock);
				n++;
			end
			check(s_data, sq.pop_front());
			@(negedge clock);
		end
		check(s_valid, 1'b0);
		ready = 1'b0;
		fcnt = 0;
	endtask : drain

	task automatic power_down();
		@(posedge sclk);
		@(negedge clock);
		pd_n = 1'b0;
		repeat (2) @(negedge clock);
		check({valid, flag, word}, 12'h000);
		check(int_ref, 1'b0);
		drain();
		// Release after a falling edge so no untracked sample is taken
		@(negedge sclk);
		repeat (2) @(negedge clock);
		pd_n = 1'b1;
		q.delete();
	endtask : power_down

	task automatic ref_sel();
		for (int s = 1; s >= 0; s--)
		begin
			@(negedge clock);
			sel = s[0];
			#1;
			check(ext_ref, s[0]);
			check(int_ref, !s[0]);
		end
	endtask : ref_sel

	// --------------------------------------------------------------
	// Main sequence and watchdog
	// --------------------------------------------------------------
	initial
	begin
		repeat (6) @(negedge clock);
		check({s_valid, b_ready, valid, flag, word}, 16'h1000);
		reset_n = 1'b1;
		run = 1'b1;
		foreach (levels[i])
			step(levels[i]);
		repeat (7)
			step(12'sh0aa);
		power_down();
		ref_sel();
		repeat (8)
			step(12'sh02d);
		drain();
		test_done();
	end

	initial
	begin
		repeat (20000) @(posedge clock);
		err_total++;
		test_done();
	end
endmodule : adc_output_capture_ctrl_tb

// *** tb/capture_partner.sv ***
// Capture-side model: sample clock source and word capture register
`timescale 1ns/1ns
module capture_partner
	import adc_capture_pkg::*;
#(
	parameter int HALF = 4
)(
	input  wire logic                  clock_in,
	input  wire logic                  run_in,
	input  wire logic [WORD_WIDTH-1:0] word_in,
	input  wire logic                  flag_in,
	output logic                       sample_clock_out,
	output sample_type                 captured_out
);
	int cnt;
	// Equal high and low halves keep the duty cycle at one half
	always @(posedge clock_in)
	begin
		if (!run_in)
		begin
			cnt <= 0;
			sample_clock_out <= 1'b0;
		end
		else
		begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1)
				sample_clock_out <= ~sample_clock_out;
		end
	end
	// Word and flag land together on one edge
	always @(posedge clock_in)
		captured_out <= '{flag_in, word_in};
endmodule : capture_partner
